// *** stpca_defines.svh ***
/*
  shared constants for the stp connection and affiliation ends.
  assumes: included by bare name from the package and modules.
*/
`ifndef STPCA_DEFINES_SVH
`define STPCA_DEFINES_SVH

// ---------------------------------------------------------------
// link symbol codes
// ---------------------------------------------------------------
`define STPCA_SYM_W       4
`define STPCA_SYM_IDLE    4'h0
`define STPCA_SYM_ALIGN   4'h1
`define STPCA_SYM_NOTIFY  4'h2
`define STPCA_SYM_CONT    4'h3
`define STPCA_SYM_SYNC    4'h4
`define STPCA_SYM_XRDY    4'h5
`define STPCA_SYM_RRDY    4'h6
`define STPCA_SYM_HOLD    4'h7
`define STPCA_SYM_DATA    4'h8
`define STPCA_SYM_INVALID 4'h9
`define STPCA_SYM_OTHER   4'ha

// ---------------------------------------------------------------
// connection codes
// ---------------------------------------------------------------
`define STPCA_ADDR_W      64
`define STPCA_REQ_W       3
`define STPCA_REQ_NONE    3'h0
`define STPCA_REQ_OPEN    3'h1
`define STPCA_REQ_ACCEPT  3'h2
`define STPCA_REQ_RETRY   3'h3
`define STPCA_REQ_BUSY    3'h4
`define STPCA_REQ_AIP     3'h5
`define STPCA_CLS_W       2
`define STPCA_CLS_NONE    2'h0
`define STPCA_CLS_NORMAL  2'h1
`define STPCA_CLS_CLRAFF  2'h2
`define STPCA_CLS_BREAK   2'h3
`define STPCA_REPEATS     2

`endif

// *** stpca_pkg.sv ***
/*
  types shared by both ends of the stp connection link.
  assumes: stpca_defines.svh is on the include path.
*/
`include "stpca_defines.svh"
package stpca_pkg;
  typedef logic [`STPCA_SYM_W-1:0]  stpca_sym_t;
  typedef logic [`STPCA_ADDR_W-1:0] stpca_addr_t;
  typedef logic [`STPCA_REQ_W-1:0]  stpca_req_t;
  typedef logic [`STPCA_CLS_W-1:0]  stpca_cls_t;
endpackage

// *** stpca_link_if.sv ***
/*
  link between the stp initiator end and the stp target end.
  assumes: one clock drives both ends; the bench joins them here.
*/
interface stpca_link_if;
  import stpca_pkg::*;
  stpca_sym_t  i2t_sym;
  stpca_sym_t  t2i_sym;
  stpca_req_t  i2t_req;
  stpca_req_t  t2i_req;
  stpca_addr_t i2t_addr;
  stpca_addr_t t2i_addr;
  stpca_cls_t  i2t_close;
  stpca_cls_t  t2i_close;
  modport init (output i2t_sym, i2t_req, i2t_addr, i2t_close,
                input  t2i_sym, t2i_req, t2i_addr, t2i_close);
  modport targ (input  i2t_sym, i2t_req, i2t_addr, i2t_close,
                output t2i_sym, t2i_req, t2i_addr, t2i_close);
endinterface

// *** stpca_cont_rx.sv ***
/*
  continued primitive receiver: tracks which primitive is held.
  assumes: one decoded symbol per clock.
*/
module stpca_cont_rx
  import stpca_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire stpca_sym_t i_sym,
  output logic [3:0]      o_prim,
  output logic            o_valid
);
  // ---------------------------------------------------------------
  // primitive hold
  // ---------------------------------------------------------------
  function automatic logic is_held(input stpca_sym_t s);
    is_held = (s == `STPCA_SYM_SYNC) || (s == `STPCA_SYM_XRDY) ||
              (s == `STPCA_SYM_RRDY) || (s == `STPCA_SYM_HOLD) ||
              (s == `STPCA_SYM_OTHER);
  endfunction

  // single instance suffices; no counting of repeats or fillers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prim  <= `STPCA_SYM_IDLE;
      o_valid <= 1'b0;
    end else if (is_held(i_sym)) begin
      o_prim  <= i_sym;
      o_valid <= 1'b1;
    end
    // cont, data, invalid, align, notify leave state alone
  end
endmodule // stpca_cont_rx

// *** stpca_target.sv ***
/*
  stp target end: affiliation, connection accept/reject, close and
  continued primitive transmit.
  assumes: link carries one symbol per clock; smp requests and sata
  side events arrive as one-cycle pulses from the surrounding bridge.
*/
module stpca_target
  import stpca_pkg::*;
#(
  parameter bit TRACKS_BY_ADDR = 1'b0,
  parameter bit IN_EXPANDER    = 1'b0
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  stpca_link_if.targ       link,
  input  wire stpca_sym_t  i_sata_sym,
  input  wire logic        i_sata_xrdy,
  input  wire stpca_addr_t i_home_addr,
  input  wire logic        i_smp_hard_reset,
  input  wire logic        i_smp_port_select,
  input  wire logic        i_smp_clear_aff,
  input  wire stpca_addr_t i_smp_src_addr,
  input  wire logic        i_link_reset,
  input  wire logic        i_link_reset_by_smp,
  input  wire logic        i_sync_lost,
  input  wire logic        i_close_req,
  output stpca_sym_t       o_sata_sym,
  output logic             o_sata_rrdy_ok,
  output logic             o_connected,
  output logic             o_aff_valid,
  output stpca_addr_t      o_aff_owner
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPENING, ST_OPEN, ST_CLOSING}
    stpca_tstate_e;

  localparam bit LOCKS = !TRACKS_BY_ADDR;

  stpca_tstate_e state_q;
  logic          aff_valid_q;
  stpca_addr_t   aff_owner_q;
  stpca_addr_t   peer_q;
  logic          sync_tx_q;
  logic          sync_rx_q;
  logic          close_tx_q;
  logic          smp_cleared_q;
  logic [1:0]    rep_q;
  stpca_sym_t    last_q;
  logic [3:0]    rx_prim;
  logic          rx_valid;

  // ---------------------------------------------------------------
  // receive side primitive tracking
  // ---------------------------------------------------------------
  stpca_cont_rx u_rx (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sym   (link.i2t_sym),
    .o_prim  (rx_prim),
    .o_valid (rx_valid)
  );

  wire req_in   = (link.i2t_req == `STPCA_REQ_OPEN);
  wire from_own = (link.i2t_addr == aff_owner_q);
  wire busy_pair = (state_q != ST_IDLE) && (link.i2t_addr == peer_q);
  wire can_close = sync_tx_q && sync_rx_q;
  wire rx_close  = (link.i2t_close != `STPCA_CLS_NONE);

  // ---------------------------------------------------------------
  // affiliation, one per port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aff_valid_q   <= 1'b0;
      aff_owner_q   <= '0;
      smp_cleared_q <= 1'b0;
    end else if (LOCKS) begin
      if (i_smp_hard_reset || i_smp_port_select ||
          (i_smp_clear_aff && aff_valid_q &&
           i_smp_src_addr == aff_owner_q)) begin
        aff_valid_q   <= 1'b0;
        smp_cleared_q <= (state_q != ST_IDLE);
      end else if (i_link_reset && !i_link_reset_by_smp) begin
        aff_valid_q <= 1'b0;
      end else if (state_q == ST_OPEN &&
                   link.i2t_close == `STPCA_CLS_CLRAFF &&
                   peer_q == aff_owner_q) begin
        aff_valid_q <= 1'b0;
      end else if (state_q == ST_IDLE && req_in &&
                   (!aff_valid_q || from_own)) begin
        aff_valid_q <= 1'b1;
        aff_owner_q <= link.i2t_addr;
      end
      if (state_q == ST_IDLE) smp_cleared_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // connection state
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q    <= ST_IDLE;
      peer_q     <= '0;
      close_tx_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          close_tx_q <= 1'b0;
          if (req_in && (!LOCKS || !aff_valid_q || from_own)) begin
            state_q <= ST_OPEN;
            peer_q  <= link.i2t_addr;
          end else if (i_sata_xrdy) begin
            state_q <= ST_OPENING;
            peer_q  <= LOCKS && aff_valid_q ? aff_owner_q : i_home_addr;
          end
        end
        ST_OPENING: begin
          if (link.i2t_req == `STPCA_REQ_ACCEPT) state_q <= ST_OPEN;
          else if (link.i2t_req == `STPCA_REQ_RETRY ||
                   link.i2t_req == `STPCA_REQ_BUSY) state_q <= ST_IDLE;
        end
        ST_OPEN: begin
          if (i_sync_lost) begin
            state_q <= ST_IDLE;
          end else if (rx_close) begin
            close_tx_q <= 1'b1;
            state_q    <= ST_IDLE;
          end else if (i_close_req && can_close) begin
            close_tx_q <= 1'b1;
            state_q    <= ST_CLOSING;
          end
        end
        ST_CLOSING: begin
          if (rx_close) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // sync handshake tracking
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_tx_q <= 1'b0;
      sync_rx_q <= 1'b0;
    end else if (state_q != ST_OPEN) begin
      sync_tx_q <= 1'b0;
      sync_rx_q <= 1'b0;
    end else begin
      if (link.t2i_sym == `STPCA_SYM_SYNC) sync_tx_q <= 1'b1;
      if (rx_valid && rx_prim == `STPCA_SYM_SYNC) sync_rx_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link.t2i_req   <= `STPCA_REQ_NONE;
      link.t2i_addr  <= '0;
      link.t2i_close <= `STPCA_CLS_NONE;
      link.t2i_sym   <= `STPCA_SYM_IDLE;
      rep_q          <= 2'h0;
      last_q         <= `STPCA_SYM_IDLE;
    end else begin
      link.t2i_req   <= `STPCA_REQ_NONE;
      link.t2i_close <= `STPCA_CLS_NONE;
      link.t2i_addr  <= peer_q;
      if (req_in && state_q != ST_IDLE) begin
        link.t2i_req <= busy_pair ? `STPCA_REQ_RETRY :
                        (LOCKS ? `STPCA_REQ_BUSY : `STPCA_REQ_RETRY);
      end else if (req_in) begin
        if (!LOCKS || !aff_valid_q || from_own)
          link.t2i_req <= `STPCA_REQ_ACCEPT;
        else
          link.t2i_req <= `STPCA_REQ_BUSY;
      end else if (req_in && smp_cleared_q) begin
        link.t2i_req <= IN_EXPANDER ? `STPCA_REQ_AIP : `STPCA_REQ_RETRY;
      end else if (state_q == ST_IDLE && i_sata_xrdy) begin
        link.t2i_req <= `STPCA_REQ_OPEN;
      end
      if (smp_cleared_q && req_in && state_q != ST_IDLE)
        link.t2i_req <= IN_EXPANDER ? `STPCA_REQ_AIP : `STPCA_REQ_RETRY;
      if ((state_q == ST_OPEN && (rx_close ||
          (i_close_req && can_close))) && !close_tx_q)
        link.t2i_close <= `STPCA_CLS_NORMAL;
      if (state_q == ST_OPEN && i_sync_lost)
        link.t2i_close <= `STPCA_CLS_BREAK;
      if (state_q == ST_OPEN && !i_sync_lost) begin
        // repeated primitive sent twice then cont
        // compare with last input: a resent primitive would end the run
        last_q <= i_sata_sym;
        if (i_sata_sym == last_q && i_sata_sym != `STPCA_SYM_DATA) begin
          if (rep_q < 2'(`STPCA_REPEATS)) begin
            link.t2i_sym <= i_sata_sym;
            rep_q        <= rep_q + 2'h1;
          end else begin
            link.t2i_sym <= `STPCA_SYM_CONT;
          end
        end else if (!sync_tx_q && i_sata_sym == `STPCA_SYM_DATA) begin
          link.t2i_sym <= `STPCA_SYM_SYNC;
          rep_q        <= 2'h1;
        end else begin
          link.t2i_sym <= i_sata_sym;
          rep_q        <= 2'h1;
        end
      end else begin
        link.t2i_sym <= `STPCA_SYM_IDLE;
        rep_q        <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // sata side and status
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sata_sym     <= `STPCA_SYM_IDLE;
      o_sata_rrdy_ok <= 1'b0;
      o_connected    <= 1'b0;
      o_aff_valid    <= 1'b0;
      o_aff_owner    <= '0;
    end else begin
      // open/close never reach the drive
      o_sata_sym     <= (state_q == ST_OPEN) ? link.i2t_sym : `STPCA_SYM_IDLE;
      o_sata_rrdy_ok <= (state_q == ST_OPEN);
      o_connected    <= (state_q == ST_OPEN);
      o_aff_valid    <= aff_valid_q;
      o_aff_owner    <= aff_owner_q;
    end
  end
endmodule // stpca_target

// *** stpca_init.sv ***
/*
  stp initiator end: one request per target, accept/retry policy,
  close kind choice and sync-gated close.
  assumes: user holds i_clear_aff with i_close_req; user keeps
  i_cmd_pending high while commands are outstanding.
*/
module stpca_init
  import stpca_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  stpca_link_if.init       link,
  input  wire stpca_addr_t i_my_addr,
  input  wire logic        i_open_req,
  input  wire logic        i_close_req,
  input  wire logic        i_clear_aff,
  input  wire logic        i_cmd_pending,
  input  wire stpca_sym_t  i_tx_sym,
  output stpca_sym_t       o_rx_sym,
  output logic             o_connected,
  output logic             o_pending
);
  typedef enum logic [1:0] {IS_IDLE, IS_WAIT, IS_OPEN, IS_CLOSING}
    stpca_istate_e;

  stpca_istate_e state_q;
  logic          sync_tx_q;
  logic          sync_rx_q;
  logic          sent_close_q;
  logic [3:0]    rx_prim;
  logic          rx_valid;

  stpca_cont_rx u_rx (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_sym   (link.t2i_sym),
    .o_prim  (rx_prim),
    .o_valid (rx_valid)
  );

  wire req_in   = (link.t2i_req == `STPCA_REQ_OPEN);
  wire rx_close = (link.t2i_close != `STPCA_CLS_NONE);
  wire close_ok = sync_tx_q && sync_rx_q;

  // ---------------------------------------------------------------
  // connection state
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q      <= IS_IDLE;
      sent_close_q <= 1'b0;
    end else begin
      case (state_q)
        IS_IDLE: begin
          sent_close_q <= 1'b0;
          if (req_in) state_q <= IS_OPEN;
          else if (i_open_req) state_q <= IS_WAIT;
        end
        IS_WAIT: begin
          // incoming from the target wins over our own
          if (req_in || link.t2i_req == `STPCA_REQ_ACCEPT)
            state_q <= IS_OPEN;
          else if (link.t2i_req == `STPCA_REQ_RETRY ||
                   link.t2i_req == `STPCA_REQ_BUSY)
            state_q <= IS_IDLE;
        end
        IS_OPEN: begin
          if (rx_close) begin
            sent_close_q <= 1'b1;
            state_q      <= IS_IDLE;
          end else if (i_close_req && close_ok) begin
            sent_close_q <= 1'b1;
            state_q      <= IS_CLOSING;
          end
        end
        IS_CLOSING: if (rx_close) state_q <= IS_IDLE;
        default: state_q <= IS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_tx_q <= 1'b0;
      sync_rx_q <= 1'b0;
    end else if (state_q != IS_OPEN) begin
      sync_tx_q <= 1'b0;
      sync_rx_q <= 1'b0;
    end else begin
      if (link.i2t_sym == `STPCA_SYM_SYNC) sync_tx_q <= 1'b1;
      if (rx_valid && rx_prim == `STPCA_SYM_SYNC) sync_rx_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link.i2t_req   <= `STPCA_REQ_NONE;
      link.i2t_addr  <= '0;
      link.i2t_close <= `STPCA_CLS_NONE;
      link.i2t_sym   <= `STPCA_SYM_IDLE;
      o_rx_sym       <= `STPCA_SYM_IDLE;
      o_connected    <= 1'b0;
      o_pending      <= 1'b0;
    end else begin
      link.i2t_addr  <= i_my_addr;
      link.i2t_req   <= `STPCA_REQ_NONE;
      link.i2t_close <= `STPCA_CLS_NONE;
      if (req_in)
        link.i2t_req <= (state_q == IS_OPEN || state_q == IS_CLOSING) ?
                        `STPCA_REQ_RETRY : `STPCA_REQ_ACCEPT;
      else if (state_q == IS_IDLE && i_open_req)
        link.i2t_req <= `STPCA_REQ_OPEN;
      // a break gets no close back; clear kind only with no queue
      if (state_q == IS_OPEN && !sent_close_q &&
          (link.t2i_close == `STPCA_CLS_NORMAL ||
           (i_close_req && close_ok)))
        link.i2t_close <= (i_clear_aff && !i_cmd_pending) ?
                          `STPCA_CLS_CLRAFF : `STPCA_CLS_NORMAL;
      if (state_q == IS_OPEN)
        link.i2t_sym <= (!sync_tx_q && i_tx_sym == `STPCA_SYM_DATA) ?
                        `STPCA_SYM_SYNC : i_tx_sym;
      else
        link.i2t_sym <= `STPCA_SYM_IDLE;
      o_rx_sym    <= rx_valid ? rx_prim : `STPCA_SYM_IDLE;
      o_connected <= (state_q == IS_OPEN);
      o_pending   <= (state_q == IS_WAIT);
    end
  end
endmodule // stpca_init

// *** stpca_link_checker.sv ***
/*
  assertions on the link between the initiator and target ends.
  assumes: one clock; the bench instantiates it beside the link.
*/
`include "stpca_defines.svh"
module stpca_link_checker
  import stpca_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire stpca_sym_t  i2t_sym,
  input wire stpca_sym_t  t2i_sym,
  input wire stpca_req_t  i2t_req,
  input wire stpca_req_t  t2i_req,
  input wire stpca_addr_t i2t_addr,
  input wire stpca_addr_t t2i_addr,
  input wire stpca_cls_t  i2t_close,
  input wire stpca_cls_t  t2i_close
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // --------------------
  // connection tracking
  // --------------------
  logic       open_q;
  logic [1:0] sync_q;
  logic [1:0] first_q;
  wire logic acc = t2i_req == `STPCA_REQ_ACCEPT ||
                   i2t_req == `STPCA_REQ_ACCEPT;
  wire logic ifil = i2t_sym inside {`STPCA_SYM_IDLE, `STPCA_SYM_ALIGN,
                                    `STPCA_SYM_NOTIFY};
  wire logic tfil = t2i_sym inside {`STPCA_SYM_IDLE, `STPCA_SYM_ALIGN,
                                    `STPCA_SYM_NOTIFY};
  wire logic isyn = i2t_sym == `STPCA_SYM_SYNC;
  wire logic tsyn = t2i_sym == `STPCA_SYM_SYNC;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) open_q <= 1'b0;
    else if (acc) open_q <= 1'b1;
    else if (i2t_close != 2'h0 || t2i_close != 2'h0) open_q <= 1'b0;
  end
  // symbols in the accept cycle count, the far end may start at once
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) sync_q <= 2'b00;
    else if (acc) sync_q <= {tsyn, isyn};
    else sync_q <= sync_q | {tsyn, isyn};
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) first_q <= 2'b00;
    else if (acc) first_q <= {tfil, ifil};
    else first_q <= first_q & {tfil, ifil};
  end
  // --------------------
  // properties
  // --------------------
  AST_OPEN_ANSWERED: assert property (
    i2t_req == `STPCA_REQ_OPEN |=> t2i_req inside {`STPCA_REQ_ACCEPT,
      `STPCA_REQ_RETRY, `STPCA_REQ_BUSY, `STPCA_REQ_AIP})
    else $error("open left unanswered");
  AST_INIT_ONE_REQ: assert property (
    i2t_req == `STPCA_REQ_OPEN |=> i2t_req != `STPCA_REQ_OPEN)
    else $error("initiator open repeated");
  AST_TGT_ONE_REQ: assert property (
    t2i_req == `STPCA_REQ_OPEN |=> t2i_req != `STPCA_REQ_OPEN)
    else $error("target open repeated");
  AST_INIT_ANSWERS: assert property (
    t2i_req == `STPCA_REQ_OPEN && i2t_req == `STPCA_REQ_NONE |=>
      i2t_req inside {`STPCA_REQ_ACCEPT, `STPCA_REQ_RETRY})
    else $error("initiator left target open unanswered");
  AST_TGT_CLOSE_KIND: assert property (
    t2i_close != `STPCA_CLS_CLRAFF)
    else $error("target sent clear close");
  AST_TGT_ECHO: assert property (
    i2t_close inside {`STPCA_CLS_NORMAL, `STPCA_CLS_CLRAFF} &&
      t2i_close == 2'h0 && $past(t2i_close) == 2'h0 |=>
      t2i_close == `STPCA_CLS_NORMAL)
    else $error("target did not answer close");
  AST_INIT_ECHO: assert property (
    t2i_close == `STPCA_CLS_NORMAL && i2t_close == 2'h0 &&
      $past(i2t_close) == 2'h0 |=>
      i2t_close inside {`STPCA_CLS_NORMAL, `STPCA_CLS_CLRAFF})
    else $error("initiator did not answer close");
  AST_CLOSE_PULSE: assert property (
    i2t_close != 2'h0 |=> (i2t_close == 2'h0)[*2])
    else $error("initiator close repeated");
  AST_FIRST_PRIM: assert property (
    !(first_q[0] && !ifil && i2t_sym == `STPCA_SYM_DATA) &&
    !(first_q[1] && !tfil && t2i_sym == `STPCA_SYM_DATA))
    else $error("data before first primitive");
  AST_CLOSE_GATED: assert property (
    open_q && (i2t_close inside {`STPCA_CLS_NORMAL, `STPCA_CLS_CLRAFF} ||
      t2i_close == `STPCA_CLS_NORMAL) |-> sync_q == 2'b11)
    else $error("close before sync both ways");
  AST_TWICE_ONLY: assert property (
    t2i_sym inside {`STPCA_SYM_SYNC, `STPCA_SYM_XRDY, `STPCA_SYM_RRDY,
      `STPCA_SYM_HOLD} && $past(t2i_sym) == t2i_sym |->
      $past(t2i_sym, 2) != t2i_sym)
    else $error("primitive sent three times");
  C_ACCEPT: cover property (i2t_req == `STPCA_REQ_OPEN ##1 acc);
  C_BUSY: cover property (t2i_req == `STPCA_REQ_BUSY);
  C_CLRAFF: cover property (i2t_close == `STPCA_CLS_CLRAFF);
  C_BREAK: cover property (t2i_close == `STPCA_CLS_BREAK);
endmodule // stpca_link_checker

// *** testbench.sv ***
/*
  bench joining the initiator and target ends over the link.
  assumes: design files and stpca_defines.svh compiled before it.
*/
`include "stpca_defines.svh"
module testbench
  import stpca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam stpca_req_t ACC = `STPCA_REQ_ACCEPT;
  localparam stpca_req_t BSY = `STPCA_REQ_BUSY;
  localparam stpca_cls_t NRM = `STPCA_CLS_NORMAL;
  localparam stpca_cls_t CLR = `STPCA_CLS_CLRAFF;
  localparam stpca_sym_t SYN = `STPCA_SYM_SYNC;
  localparam stpca_sym_t HLD = `STPCA_SYM_HOLD;
  localparam stpca_sym_t DAT = `STPCA_SYM_DATA;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        open_req, close_req, clear_aff, cmd_pend, xrdy, tclose;
  logic        hard_rst, port_sel, smp_clr, lnk_rst, lnk_by_smp, sync_lost;
  stpca_addr_t my_addr, home_addr, smp_addr, addr_a, lock_own, aff_own;
  stpca_sym_t  tx_sym, sata_sym, rx_sym, sata_out;
  logic        i_conn, t_conn, pending, rrdy_ok, aff_v, lock_v;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'he0908e78;
  stpca_link_if u_stpca_link_if ();
  wire stpca_sym_t i2t_sym   = u_stpca_link_if.i2t_sym;
  wire stpca_sym_t t2i_sym   = u_stpca_link_if.t2i_sym;
  wire stpca_req_t i2t_req   = u_stpca_link_if.i2t_req;
  wire stpca_req_t t2i_req   = u_stpca_link_if.t2i_req;
  wire stpca_cls_t i2t_close = u_stpca_link_if.i2t_close;
  wire stpca_cls_t t2i_close = u_stpca_link_if.t2i_close;
  stpca_init u_stpca_init (.i_clk, .i_rst, .link(u_stpca_link_if),
    .i_my_addr(my_addr), .i_open_req(open_req), .i_close_req(close_req),
    .i_clear_aff(clear_aff), .i_cmd_pending(cmd_pend), .i_tx_sym(tx_sym),
    .o_rx_sym(rx_sym), .o_connected(i_conn), .o_pending(pending));
  stpca_target #(.TRACKS_BY_ADDR(1'b0), .IN_EXPANDER(1'b0)) u_stpca_target (
    .i_clk, .i_rst, .link(u_stpca_link_if), .i_sata_sym(sata_sym),
    .i_sata_xrdy(xrdy), .i_home_addr(home_addr), .i_smp_hard_reset(hard_rst),
    .i_smp_port_select(port_sel), .i_smp_clear_aff(smp_clr),
    .i_smp_src_addr(smp_addr), .i_link_reset(lnk_rst),
    .i_link_reset_by_smp(lnk_by_smp), .i_sync_lost(sync_lost),
    .i_close_req(tclose), .o_sata_sym(sata_out), .o_sata_rrdy_ok(rrdy_ok),
    .o_connected(t_conn), .o_aff_valid(aff_v), .o_aff_owner(aff_own));
  stpca_link_checker u_stpca_link_checker (.i_clk, .i_rst, .i2t_sym,
    .t2i_sym, .i2t_req, .t2i_req, .i2t_addr(u_stpca_link_if.i2t_addr),
    .t2i_addr(u_stpca_link_if.t2i_addr), .i2t_close, .t2i_close);
  always #5 i_clk = ~i_clk;
  // --------------------
  // helpers
  // --------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[ERR] %0t run timed out", $time);
      print_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [64:0] got, input logic [64:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // lock model: a foreign address is turned away while a lock stands
  function automatic stpca_req_t exp_ans(input stpca_addr_t a);
    return (lock_v && a != lock_own) ? BSY : ACC;
  endfunction
  task automatic do_open(input stpca_addr_t a, input stpca_req_t e);
    int k;
    my_addr = a;
    open_req = 1'b1;
    for (k = 0; k < 20 && t2i_req === 3'h0; k++) tick(1);
    open_req = 1'b0;
    chk(t2i_req, e, "open answer");
    chk(pending, 1'b1, "pending");
    tick(3);
    if (e === ACC) begin
      chk({i_conn, t_conn}, 2'b11, "connected");
      lock_v = 1'b1;
      lock_own = a;
      chk({aff_v, aff_own}, {1'b1, a}, "lock owner");
    end
  endtask
  task automatic do_close(input logic clr, input logic pend);
    int k;
    clear_aff = clr;
    cmd_pend = pend;
    close_req = 1'b1;
    for (k = 0; k < 30 && i2t_close === 2'h0; k++) tick(1);
    chk(i2t_close, (clr && !pend) ? CLR : NRM, "close kind");
    tick(1);
    chk(t2i_close, NRM, "close echo");
    {close_req, clear_aff, cmd_pend} = 3'b000;
    tick(3);
    if (clr && !pend) lock_v = 1'b0;
    chk({i_conn, t_conn, aff_v}, {2'b00, lock_v}, "closed");
  endtask
  // --------------------
  // scenarios
  // --------------------
  initial begin
    stpca_addr_t a;
    logic [31:0] r;
    int          i, k, n;
    {open_req, close_req, clear_aff, cmd_pend, xrdy, tclose} = '0;
    {hard_rst, port_sel, smp_clr, lnk_rst, lnk_by_smp, sync_lost} = '0;
    {my_addr, home_addr, smp_addr, lock_own} = '0;
    tx_sym = SYN;
    sata_sym = SYN;
    lock_v = 1'b0;
    addr_a = {rnd(), rnd()};
    tick(10);
    i_rst = 1'b0;
    for (i = 0; i < 12; i++) begin
      r = rnd();
      a = r[0] ? addr_a : ~addr_a;
      do_open(a, exp_ans(a));
      if (exp_ans(a) === ACC) do_close(r[1], r[2]);
    end
    if (!lock_v) begin
      do_open(addr_a, ACC);
      do_close(1'b0, 1'b0);
    end
    do_open(lock_own ^ 64'h1, BSY);
    $display("test lock done");
    // event kinds: hard reset, port select, clear by owner and by other,
    // link reset asked by smp, link reset from the drive side
    for (k = 0; k < 6; k++) begin
      do_open(lock_v ? lock_own : addr_a, ACC);
      do_close(1'b0, 1'b0);
      smp_addr = (k == 3) ? ~lock_own : lock_own;
      lnk_by_smp = (k == 4);
      {hard_rst, port_sel, smp_clr, lnk_rst} =
        {k == 0, k == 1, k inside {2, 3}, k > 3};
      tick(1);
      {hard_rst, port_sel, smp_clr, lnk_rst, lnk_by_smp} = '0;
      tick(2);
      if (k inside {0, 1, 2, 5}) lock_v = 1'b0;
      chk(aff_v, lock_v, "lock after event");
    end
    $display("test events done");
    do_open(addr_a, exp_ans(addr_a));
    if (!t_conn) do_open(lock_own, ACC);
    sata_sym = HLD;
    n = 0;
    repeat (6) begin
      tick(1);
      if (t2i_sym === `STPCA_SYM_CONT) n++;
    end
    chk(n, 4, "cont sent");
    chk(rx_sym, HLD, "held primitive");
    sata_sym = SYN;
    tx_sym = DAT;
    for (k = 0; k < 10 && sata_out !== DAT; k++) tick(1);
    chk(sata_out, DAT, "forwarded");
    tx_sym = SYN;
    tick(4);
    do_close(1'b0, 1'b0);
    do_open(lock_own, ACC);
    sync_lost = 1'b1;
    tick(1);
    sync_lost = 1'b0;
    for (k = 0; k < 10 && t2i_close !== `STPCA_CLS_BREAK; k++) tick(1);
    chk(t2i_close, `STPCA_CLS_BREAK, "break");
    tick(4);
    chk({i_conn, t_conn}, 2'b00, "broken");
    $display("test stream done");
    home_addr = lock_own;
    my_addr = lock_own;
    xrdy = 1'b1;
    tick(1);
    xrdy = 1'b0;
    n = 0;
    i = 0;
    for (k = 0; k < 20 && t_conn !== 1'b1; k++) begin
      if (rrdy_ok === 1'b1) n++;
      if (i2t_req === ACC) i = 1;
      tick(1);
    end
    chk(n, 0, "ready before open");
    chk(i, 1, "target open accepted");
    for (k = 0; k < 10 && rrdy_ok !== 1'b1; k++) tick(1);
    chk(rrdy_ok, 1'b1, "ready after open");
    tick(4);
    tclose = 1'b1;
    for (k = 0; k < 30 && t2i_close === 2'h0; k++) tick(1);
    chk(t2i_close, NRM, "target close kind");
    tick(1);
    chk(i2t_close, NRM, "close answer");
    tclose = 1'b0;
    tick(3);
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
    tick(1);
    chk({aff_v, i_conn, t_conn}, 3'b000, "cleared by reset");
    $display("test drive ready done");
    print_verdict();
  end
endmodule // testbench
